// File: bench/tef_timer_event_tb.sv
`timescale 1ns/100ps
module tef_timer_event_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdVal;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, rdErr;
    logic [15:0] coreCounter = 16'h1234, capVal, c2, cnt;
    logic        repCounterWrap = 1'b0, swReinit = 1'b0, trigReinit = 1'b0;
    logic        trigEvent = 1'b0, chan1CaptureEvent = 1'b0, filteredExternalTrigger = 1'b0;
    logic        updateEvent, irq, chan2OutputReference, chan2Output, chan2ComplementOutput;
    int          fails = 0;
    int          checks_done = 0;
    localparam logic [7:0] OFFS [7] = '{tef_pkg::CTRL_OFS, tef_pkg::MASK_OFS, tef_pkg::STAT_OFS,
        tef_pkg::EVGEN_OFS, tef_pkg::CHCTL1_OFS, tef_pkg::CCR1_OFS, tef_pkg::CCR2_OFS};

    // 25 ns period
    always #12.5 core_clk = ~core_clk;

    tef_timer_event i_tef_timer_event (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreCounter(coreCounter),
        .repCounterWrap(repCounterWrap), .swReinit(swReinit), .trigReinit(trigReinit),
        .trigEvent(trigEvent), .chan1CaptureEvent(chan1CaptureEvent),
        .filteredExternalTrigger(filteredExternalTrigger), .updateEvent(updateEvent), .irq(irq),
        .chan2OutputReference(chan2OutputReference), .chan2Output(chan2Output),
        .chan2ComplementOutput(chan2ComplementOutput));

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // APB master: starts one edge on, so no signal is set twice per step
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(pready === 1'b1) && n < 40);
        if (n >= 40) begin
            fails++;
            finish_test();
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdVal, e);
    endtask

    // One-cycle pulse on an event input; update output checked 1 ns after the edge
    task automatic pulse(input int k, input logic expUpd);
        @(posedge core_clk);
        case (k)
            0: repCounterWrap <= 1'b1;
            1: swReinit <= 1'b1;
            2: trigReinit <= 1'b1;
            3: trigEvent <= 1'b1;
            default: chan1CaptureEvent <= 1'b1;
        endcase
        #1 chk(32'(updateEvent), 32'(expUpd));
        @(posedge core_clk);
        {repCounterWrap, swReinit, trigReinit, trigEvent, chan1CaptureEvent} <= 5'h00;
    endtask

    // ------------------------------------------------------------------
    // Expectations: c[0] update disable, c[1] source select; k=0 wrap
    // ------------------------------------------------------------------
    function automatic logic updExp(input int c, input int k);
        return (k == 0) ? !c[0] : (!c[0] && !c[1]);
    endfunction

    function automatic logic refExp(input int m, input logic [15:0] n, input logic [15:0] r);
        return (m == 5) || (m == 6 && n < r) || (m == 7 && n >= r);
    endfunction

    task automatic refchk(input logic e);
        repeat (2) @(posedge core_clk);
        #1 chk(32'(chan2OutputReference), 32'(e));
        chk(32'({chan2Output, chan2ComplementOutput}), 32'({e, !e}));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(12));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (OFFS[i]) rdchk(OFFS[i], 32'h0);
        chk(32'(rdErr), 32'h0);
        chk(32'(irq), 32'h0);
        rdchk(8'h04, 32'h0);
        chk(32'(rdErr), 32'h1);
        chk(32'(pready), 32'h1);
        // Every settings combination against every update cause (k=3: generate bit)
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 4; k++) begin
                wr(tef_pkg::CTRL_OFS, 32'(c) << 1);
                wr(tef_pkg::STAT_OFS, 32'h0);
                if (k == 3) wr(tef_pkg::EVGEN_OFS, 32'h1);
                else pulse(k, updExp(c, k));
                rdchk(tef_pkg::STAT_OFS, 32'(updExp(c, k)));
            end
        end
        wr(tef_pkg::CTRL_OFS, 32'h2);
        wr(tef_pkg::STAT_OFS, 32'h0);
        wr(tef_pkg::EVGEN_OFS, 32'h0);
        rdchk(tef_pkg::STAT_OFS, 32'h0);
        wr(tef_pkg::EVGEN_OFS, 32'h40);
        rdchk(tef_pkg::STAT_OFS, 32'h40);
        chk(32'(irq), 32'h0);
        wr(tef_pkg::MASK_OFS, 32'h40);
        #1 chk(32'(irq), 32'h1);
        wr(tef_pkg::STAT_OFS, 32'h47);
        rdchk(tef_pkg::STAT_OFS, 32'h40);
        wr(tef_pkg::STAT_OFS, 32'h0);
        #1 chk(32'(irq), 32'h0);
        pulse(3, 1'b0);
        rdchk(tef_pkg::STAT_OFS, 32'h40);
        rdchk(tef_pkg::EVGEN_OFS, 32'h0);
        // Channel event generation, one bit at a time
        for (int b = 1; b < 3; b++) begin
            wr(tef_pkg::STAT_OFS, 32'h0);
            wr(tef_pkg::EVGEN_OFS, 32'h1 << b);
            rdchk(tef_pkg::STAT_OFS, 32'h1 << b);
        end
        // Compare match on a random value; counter steered away first
        // Ends of the range excluded so neither value nor its inverse hits compare 2 at zero
        capVal = 16'($urandom_range(32'h0000_fffe, 32'h0000_0001));
        coreCounter <= ~capVal;
        wr(tef_pkg::CCR1_OFS, 32'(capVal));
        wr(tef_pkg::STAT_OFS, 32'h0);
        rdchk(tef_pkg::STAT_OFS, 32'h0);
        coreCounter <= capVal;
        @(posedge core_clk);
        coreCounter <= ~capVal;
        rdchk(tef_pkg::STAT_OFS, 32'h2);
        // Input mode: capture, then a read of the capture register clears
        wr(tef_pkg::CHCTL1_OFS, 32'h1);
        rdchk(tef_pkg::CHCTL1_OFS, 32'h1);
        wr(tef_pkg::STAT_OFS, 32'h0);
        capVal = 16'($urandom_range(32'h0000_fffe, 32'h0000_0001));
        coreCounter <= capVal;
        pulse(4, 1'b0);
        rdchk(tef_pkg::STAT_OFS, 32'h2);
        rdchk(tef_pkg::CCR1_OFS, 32'(capVal));
        rdchk(tef_pkg::STAT_OFS, 32'h0);
        cnt = 16'($urandom);
        wr(tef_pkg::CHCTL1_OFS, 32'(cnt));
        rdchk(tef_pkg::CHCTL1_OFS, 32'(cnt));
        // Upper byte strobe only: the low byte must survive
        pstrb <= 4'h2;
        wr(tef_pkg::CHCTL1_OFS, 32'h0);
        pstrb <= 4'hf;
        rdchk(tef_pkg::CHCTL1_OFS, 32'(cnt & 16'h00ff));
        // Channel 2 reference: forced and PWM modes, PWM2 on the equal boundary
        c2 = 16'($urandom);
        wr(tef_pkg::CCR2_OFS, 32'(c2));
        for (int m = 4; m < 8; m++) begin
            cnt = (m == 7) ? c2 : 16'($urandom);
            coreCounter <= cnt;
            wr(tef_pkg::CHCTL1_OFS, 32'(m) << 12);
            refchk(refExp(m, cnt, c2));
        end
        // Match modes with the count parked on compare 2: low, high, then frozen keeps high
        for (int m = 2; m >= 0; m--) begin
            wr(tef_pkg::CHCTL1_OFS, 32'(m) << 12);
            refchk(m != 2);
        end
        // Toggle: no change off the match, one flip for a single matching cycle
        coreCounter <= ~c2;
        wr(tef_pkg::CHCTL1_OFS, 32'h0000_3000);
        coreCounter <= c2;
        @(posedge core_clk);
        coreCounter <= ~c2;
        refchk(1'b0);
        wr(tef_pkg::CHCTL1_OFS, 32'h0000d000);
        filteredExternalTrigger <= 1'b1;
        refchk(1'b0);
        filteredExternalTrigger <= 1'b0;
        refchk(1'b1);
        wr(tef_pkg::CHCTL1_OFS, 32'h00005100);
        refchk(1'b0);
        finish_test();
    end
endmodule

// File: src/tef_pkg.sv
// ----------------------------------------------------------------------------
// Timer event flags and channel control: shared constants
// ----------------------------------------------------------------------------
package tef_pkg;

    // ------------------------------------------------------------------------
    // Register byte offsets on the APB window
    // ------------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;   // Update disable and source select
    localparam logic [7:0] MASK_OFS   = 8'h0c;   // Interrupt enables, same layout as status
    localparam logic [7:0] STAT_OFS   = 8'h10;   // Sticky event flags
    localparam logic [7:0] EVGEN_OFS  = 8'h14;   // Software event generation
    localparam logic [7:0] CHCTL1_OFS = 8'h18;   // Channel control one
    localparam logic [7:0] CCR1_OFS   = 8'h34;   // Compare/capture value, channel 1
    localparam logic [7:0] CCR2_OFS   = 8'h38;   // Compare value, channel 2

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int UPDATE_DISABLE_BIT   = 1;              // Control: update disable
    localparam int URS_BIT    = 2;              // Control: update source select
    localparam int UPD_BIT    = 0;              // Status/event: update
    localparam int CC1_BIT    = 1;              // Status/event: channel 1
    localparam int CC2_BIT    = 2;              // Status/event: channel 2
    localparam int TRG_BIT    = 6;              // Status/event: trigger
    localparam int CC1S_LSB   = 0;              // Channel 1 direction select, 2 bits
    localparam int CC2S_LSB   = 8;              // Channel 2 direction select, 2 bits
    localparam int CHAN2_OUTPUT_BEHAVIOUR_LSB   = 12;             // Channel 2 output behaviour, 3 bits
    localparam int CHAN2_REF_CLEAR_ENABLE_BIT  = 15;             // Channel 2 reference clear enable

    // ------------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------------
    localparam logic [15:0] CTRL_WMASK  = 16'h0006;
    localparam logic [15:0] STAT_WMASK  = 16'h0047;
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] MASK_RST    = 16'h0000;
    localparam logic [15:0] STAT_RST    = 16'h0000;
    localparam logic [15:0] CHCTL1_RST  = 16'h0000;
    localparam logic [15:0] CCR_RST     = 16'h0000;
    localparam logic [1:0]  DIR_OUTPUT  = 2'h0;   // Direction code for compare output

    // ------------------------------------------------------------------------
    // Output behaviour of channel 2 reference
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        OCM_FROZEN     = 3'h0,
        OCM_MATCH_HIGH = 3'h1,
        OCM_MATCH_LOW  = 3'h2,
        OCM_TOGGLE     = 3'h3,
        OCM_FORCE_LOW  = 3'h4,
        OCM_FORCE_HIGH = 3'h5,
        OCM_PWM1       = 3'h6,
        OCM_PWM2       = 3'h7
    } tef_ocmode_t;

endpackage

// File: src/tef_timer_event.sv
`timescale 1ns/100ps

module tef_timer_event (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Counter core, same clock
    input  wire logic [15:0] coreCounter,
    input  wire logic        repCounterWrap,
    input  wire logic        swReinit,
    input  wire logic        trigReinit,
    input  wire logic        trigEvent,
    input  wire logic        chan1CaptureEvent,
    input  wire logic        filteredExternalTrigger,
    // Results
    output logic             updateEvent,
    output logic             irq,
    output logic             chan2OutputReference,
    output logic             chan2Output,
    output logic             chan2ComplementOutput
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] mask_q;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [15:0] chctl_q;
    logic [15:0] ccr1_q;
    logic [15:0] ccr2_q;
    logic        ref_q;
    logic        ref_d;
    logic        upd_q;
    logic [31:0] prdata_q;
    logic        slverr_q;
    logic        setupPh;
    logic        wrEn;
    logic        rdEn;
    logic [15:0] byteEn;
    logic [15:0] setVec;
    logic [15:0] clrVec;
    logic        ugPulse;
    logic        cc1gPulse;
    logic        cc2gPulse;
    logic        tgPulse;
    logic        updateDisable;
    logic        updateSourceSelect;
    logic        ch1IsOutput;
    logic        ch2IsOutput;
    logic        cmp1Match;
    logic        cmp2Match;
    logic        capture1;
    logic        refClearEnable;
    tef_pkg::tef_ocmode_t chan2Behaviour;

    // Merge a write into a register under the byte strobes
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] val,
                                           input logic [15:0] be);
        wmerge = (old & ~be) | (val & be);
    endfunction

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign setupPh = psel & ~penable;
    assign wrEn    = psel & penable & pwrite;
    assign rdEn    = psel & penable & ~pwrite;
    assign byteEn  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q & psel & penable;

    // Field views of the control registers
    assign updateDisable      = ctrl_q[tef_pkg::UPDATE_DISABLE_BIT];
    assign updateSourceSelect = ctrl_q[tef_pkg::URS_BIT];
    assign ch1IsOutput    = chctl_q[tef_pkg::CC1S_LSB +: 2] == tef_pkg::DIR_OUTPUT;
    assign ch2IsOutput    = chctl_q[tef_pkg::CC2S_LSB +: 2] == tef_pkg::DIR_OUTPUT;
    assign refClearEnable = chctl_q[tef_pkg::CHAN2_REF_CLEAR_ENABLE_BIT];
    assign chan2Behaviour = tef_pkg::tef_ocmode_t'(chctl_q[tef_pkg::CHAN2_OUTPUT_BEHAVIOUR_LSB +: 3]);

    // ------------------------------------------------------------------------
    // Software event generation
    // ------------------------------------------------------------------------
    // Bits are never stored, so they read back zero: the self-clear is immediate
    // trigger generate bit
    assign tgPulse   = wrEn & (paddr == tef_pkg::EVGEN_OFS) & pstrb[0] & pwdata[tef_pkg::TRG_BIT];
    assign cc1gPulse = wrEn & (paddr == tef_pkg::EVGEN_OFS) & pstrb[0] & pwdata[tef_pkg::CC1_BIT];
    assign cc2gPulse = wrEn & (paddr == tef_pkg::EVGEN_OFS) & pstrb[0] & pwdata[tef_pkg::CC2_BIT];
    assign ugPulse   = wrEn & (paddr == tef_pkg::EVGEN_OFS) & pstrb[0] & pwdata[tef_pkg::UPD_BIT];

    // ------------------------------------------------------------------------
    // Update event sources
    // ------------------------------------------------------------------------
    // wrap updates; soft sources need source select clear
    assign updateEvent = ~updateDisable &
                         (repCounterWrap | (~updateSourceSelect & (ugPulse | swReinit | trigReinit)));

    // ------------------------------------------------------------------------
    // Channel compare and capture
    // ------------------------------------------------------------------------
    // match only counts in output mode
    assign cmp1Match = ch1IsOutput & (coreCounter == ccr1_q);
    assign cmp2Match = ch2IsOutput & (coreCounter == ccr2_q);
    assign capture1  = ~ch1IsOutput & (chan1CaptureEvent | cc1gPulse);

    // Flag set sources
    always_comb begin
        setVec                   = 16'h0000;
        setVec[tef_pkg::UPD_BIT] = updateEvent;
        setVec[tef_pkg::CC1_BIT] = cmp1Match | capture1 | cc1gPulse;
        setVec[tef_pkg::CC2_BIT] = cmp2Match | cc2gPulse;
        setVec[tef_pkg::TRG_BIT] = trigEvent | tgPulse;
    end

    // Flag clear sources; a written zero clears, a written one is ignored
    always_comb begin
        clrVec = 16'h0000;
        if (wrEn && paddr == tef_pkg::STAT_OFS) begin
            clrVec = ~pwdata[15:0] & byteEn & tef_pkg::STAT_WMASK;
        end
        if (rdEn && paddr == tef_pkg::CCR1_OFS && !ch1IsOutput) begin
            clrVec[tef_pkg::CC1_BIT] = 1'b1;
        end
    end

    assign stat_d = (stat_q & ~clrVec) | setVec;

    // ------------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stat_q <= tef_pkg::STAT_RST;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Interrupt: level, high while an enabled flag stands
    // trigger interrupt when enabled
    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------------------
    // Control, mask and channel control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q  <= tef_pkg::CTRL_RST;
            mask_q  <= tef_pkg::MASK_RST;
            chctl_q <= tef_pkg::CHCTL1_RST;
        end else if (wrEn) begin
            if (paddr == tef_pkg::CTRL_OFS) begin
                ctrl_q <= wmerge(ctrl_q, pwdata[15:0], byteEn & tef_pkg::CTRL_WMASK);
            end
            if (paddr == tef_pkg::MASK_OFS) begin
                mask_q <= wmerge(mask_q, pwdata[15:0], byteEn & tef_pkg::STAT_WMASK);
            end
            if (paddr == tef_pkg::CHCTL1_OFS) begin
                chctl_q <= wmerge(chctl_q, pwdata[15:0], byteEn);
            end
        end
    end

    // Compare/capture 1: software value in output mode, captured count in input mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ccr1_q <= tef_pkg::CCR_RST;
        end else if (capture1) begin
            ccr1_q <= coreCounter;
        end else if (wrEn && paddr == tef_pkg::CCR1_OFS && ch1IsOutput) begin
            ccr1_q <= wmerge(ccr1_q, pwdata[15:0], byteEn);
        end
    end

    // Compare 2: no preload, a new value acts at once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ccr2_q <= tef_pkg::CCR_RST;
        end else if (wrEn && paddr == tef_pkg::CCR2_OFS) begin
            ccr2_q <= wmerge(ccr2_q, pwdata[15:0], byteEn);
        end
    end

    // ------------------------------------------------------------------------
    // Channel 2 output reference
    // ------------------------------------------------------------------------
    // PWM assumes an up-counting core; down counting would need a direction input
    always_comb begin
        case (chan2Behaviour)
            tef_pkg::OCM_FROZEN:     ref_d = ref_q;
            tef_pkg::OCM_MATCH_HIGH: ref_d = cmp2Match ? 1'b1 : ref_q;
            tef_pkg::OCM_MATCH_LOW:  ref_d = cmp2Match ? 1'b0 : ref_q;
            tef_pkg::OCM_TOGGLE:     ref_d = cmp2Match ? ~ref_q : ref_q;
            tef_pkg::OCM_FORCE_LOW:  ref_d = 1'b0;
            tef_pkg::OCM_FORCE_HIGH: ref_d = 1'b1;
            tef_pkg::OCM_PWM1:       ref_d = coreCounter < ccr2_q;
            tef_pkg::OCM_PWM2:       ref_d = ~(coreCounter < ccr2_q);
            default:                 ref_d = ref_q;
        endcase
        if (refClearEnable && filteredExternalTrigger) begin
            ref_d = 1'b0;
        end
        // no output meaning in input mode
        if (!ch2IsOutput) begin
            ref_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
        end
    end

    // Polarity selection lives outside this block: the output follows the reference, the complement its inverse
    assign chan2OutputReference  = ref_q;
    assign chan2Output           = ref_q;
    assign chan2ComplementOutput = ~ref_q;

    // ------------------------------------------------------------------------
    // Read data, latched in the setup cycle
    // ------------------------------------------------------------------------
    // Sampling in setup keeps prdata a flop; a flag raised during access shows next read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setupPh) begin
            slverr_q <= 1'b0;
            case (paddr)
                tef_pkg::CTRL_OFS:   prdata_q <= {16'h0000, ctrl_q};
                tef_pkg::MASK_OFS:   prdata_q <= {16'h0000, mask_q};
                tef_pkg::STAT_OFS:   prdata_q <= {16'h0000, stat_q};
                tef_pkg::EVGEN_OFS:  prdata_q <= 32'h0000_0000;
                tef_pkg::CHCTL1_OFS: prdata_q <= {16'h0000, chctl_q};
                tef_pkg::CCR1_OFS:   prdata_q <= {16'h0000, ccr1_q};
                tef_pkg::CCR2_OFS:   prdata_q <= {16'h0000, ccr2_q};
                default: begin
                    prdata_q <= 32'h0000_0000;
                    slverr_q <= 1'b1;
                end
            endcase
        end
    end

    // Registered copy of the update strobe, for the checks below
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= updateEvent;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    cmp1_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp1Match |=> stat_q[tef_pkg::CC1_BIT])
        else $error("channel 1 match did not set its flag");

    cap1_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!ch1IsOutput && chan1CaptureEvent) |=> stat_q[tef_pkg::CC1_BIT] && ccr1_q == $past(coreCounter))
        else $error("capture did not store count and flag");

    cap1_rdclr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rdEn && paddr == tef_pkg::CCR1_OFS && !ch1IsOutput && !setVec[tef_pkg::CC1_BIT])
        |=> !stat_q[tef_pkg::CC1_BIT])
        else $error("capture read did not clear channel 1 flag");

    upd_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        upd_q |-> stat_q[tef_pkg::UPD_BIT])
        else $error("update event did not set update flag");

    upd_disable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        updateDisable |-> !updateEvent)
        else $error("update produced while disabled");

    wrap_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (repCounterWrap && !updateDisable) |-> updateEvent ##1 stat_q[tef_pkg::UPD_BIT])
        else $error("repetition wrap gave no update");

    ug_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ugPulse || swReinit) && !updateDisable && !updateSourceSelect |-> updateEvent)
        else $error("update generate or reinit gave no update");

    urs_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (updateSourceSelect && !repCounterWrap) |-> !updateEvent)
        else $error("soft source updated while source select set");

    trg_reinit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trigReinit && !updateDisable && !updateSourceSelect) |-> updateEvent)
        else $error("trigger reinit gave no update");

    tg_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        tgPulse |=> stat_q[tef_pkg::TRG_BIT])
        else $error("trigger generate did not set trigger flag");

    tg_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tgPulse && mask_q[tef_pkg::TRG_BIT] && !(wrEn && paddr == tef_pkg::MASK_OFS)) |=> irq)
        else $error("enabled trigger raised no interrupt");

    chan2_event_generate_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cc2gPulse |=> stat_q[tef_pkg::CC2_BIT])
        else $error("channel 2 generate set no flag");

    chan1_event_generate_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cc1gPulse |=> stat_q[tef_pkg::CC1_BIT])
        else $error("channel 1 generate set no flag");

    ch2_input_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ch2IsOutput |=> !ref_q)
        else $error("reference driven while channel 2 is input");

    ref_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (refClearEnable && filteredExternalTrigger) |=> !chan2OutputReference)
        else $error("external trigger did not clear reference");

    force_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ch2IsOutput && chan2Behaviour == tef_pkg::OCM_FORCE_HIGH && !(refClearEnable && filteredExternalTrigger))
        |=> chan2Output && !chan2ComplementOutput)
        else $error("force high not seen on channel 2 outputs");

    one_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrEn && paddr == tef_pkg::STAT_OFS && pstrb[0] && pwdata[tef_pkg::UPD_BIT] && stat_q[tef_pkg::UPD_BIT])
        |=> stat_q[tef_pkg::UPD_BIT])
        else $error("writing one cleared the update flag");

endmodule
